// *** core/eal_defines.svh ***
// constants for the addressable latch controller
`ifndef EAL_DEFINES_SVH
`define EAL_DEFINES_SVH
`define EAL_ADDR_W 3
`define EAL_LATCH_N 8
// settle time between pin steps, in ns as drawn, and in cycles at 40 MHz
`define EAL_SETTLE_NS 25
`define EAL_CLK_NS 25
`define EAL_SETTLE_CYC ((`EAL_SETTLE_NS + `EAL_CLK_NS - 1) / `EAL_CLK_NS)
`define EAL_CMD_WRITE 2'h0
`define EAL_CMD_CLEAR 2'h1
`define EAL_CMD_DEMUX 2'h2
`define EAL_CMD_HOLD 2'h3
`endif

// *** core/eal_pkg.sv ***
// types for the addressable latch controller
`default_nettype none
package eal_pkg;
  typedef enum logic [2:0] {
    EAL_IDLE = 3'h0,
    EAL_ADDR = 3'h1,
    EAL_STRB = 3'h3,
    EAL_CLRS = 3'h2,
    EAL_DMXS = 3'h6,
    EAL_DMXE = 3'h7
  } eal_state_t;
endpackage
`default_nettype wire

// *** core/eal_ctrl.sv ***
// host controller that drives an eight-bit addressable latch through its pins
`timescale 1ns/1ps
`include "eal_defines.svh"
`default_nettype none
module eal_ctrl
  import eal_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [`EAL_ADDR_W-1:0] cmd_addr_in,
  input wire logic cmd_data_in,
  output logic cmd_ready_out,
  output logic addr_bit0_out,
  output logic addr_bit1_out,
  output logic addr_bit2_out,
  output logic data_out,
  output logic enable_n_out,
  output logic wipe_all_n_out,
  output logic inited_out
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    eal_state_t st;
    logic [`EAL_ADDR_W-1:0] addr;
    logic data;
    logic en_n;
    logic wipe_n;
    logic inited;
    // a write that arrives in demux mode waits here until the exit is done
    logic pend;
    logic [`EAL_ADDR_W-1:0] paddr;
    logic pdata;
    logic [1:0] cnt;
  } eal_regs_t;

  eal_regs_t r;
  eal_regs_t next_r;

  // one settle cycle per pin step; the count field is sized for that
  localparam logic [1:0] SETTLE = 2'(`EAL_SETTLE_CYC);

  ////////////////////////////////////////////////////////////////////////
  // demux is the one mode with both pins low; leaving it is order-critical
  function automatic logic eal_is_demux(input logic en_n, input logic wipe_n);
    return !en_n && !wipe_n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic: each command walks enable and wipe so no wrong latch loads
  always_comb begin
    next_r = r;
    if (r.cnt != 2'h0) begin
      next_r.cnt = r.cnt - 2'h1;
    end else begin
      unique case (r.st)
        EAL_IDLE: begin
          if (r.pend) begin
            // the deferred write: demux is left and the latch disabled
            next_r.addr = r.paddr;
            next_r.data = r.pdata;
            next_r.pend = 1'b0;
            next_r.st = EAL_ADDR;
            next_r.cnt = SETTLE;
          end else if (cmd_valid_in) begin
            unique case (cmd_op_in)
              `EAL_CMD_WRITE: begin
                if (eal_is_demux(r.en_n, r.wipe_n)) begin
                  // out of demux, wipe must rise under enable before the address may move
                  next_r.wipe_n = 1'b1;
                  next_r.paddr = cmd_addr_in;
                  next_r.pdata = cmd_data_in;
                  next_r.pend = 1'b1;
                  next_r.st = EAL_DMXE;
                  next_r.cnt = SETTLE;
                end else begin
                  // address moves only while disabled and wipe high
                  // a zero to a location wired to wipe resets all, a one restores
                  next_r.en_n = 1'b1;
                  next_r.wipe_n = 1'b1;
                  next_r.addr = cmd_addr_in;
                  next_r.data = cmd_data_in;
                  next_r.st = EAL_ADDR;
                  next_r.cnt = SETTLE;
                end
              end
              `EAL_CMD_CLEAR: begin
                // entering clear needs no ordering
                next_r.en_n = 1'b1;
                next_r.wipe_n = 1'b0;
                next_r.st = EAL_CLRS;
                next_r.cnt = SETTLE;
              end
              `EAL_CMD_DEMUX: begin
                // disable first so the address change sees memory or clear mode
                next_r.en_n = 1'b1;
                next_r.addr = cmd_addr_in;
                next_r.data = cmd_data_in;
                next_r.st = EAL_DMXS;
                next_r.cnt = SETTLE;
              end
              `EAL_CMD_HOLD: begin
                // hold: memory mode; leaving demultiplex raises wipe first
                next_r.wipe_n = 1'b1;
                next_r.st = EAL_DMXE;
                next_r.cnt = SETTLE;
              end
            endcase
          end
        end
        EAL_ADDR: begin
          // strobe the enable with address already stable
          next_r.en_n = 1'b0;
          next_r.st = EAL_STRB;
          next_r.cnt = SETTLE;
        end
        EAL_STRB: begin
          next_r.en_n = 1'b1; // store and return to memory mode
          next_r.st = EAL_IDLE;
        end
        EAL_CLRS: begin
          // clear leaves to memory; the address is never touched here
          next_r.wipe_n = 1'b1;
          next_r.inited = 1'b1; // contents are known once the clear pulse ends
          next_r.st = EAL_IDLE;
        end
        EAL_DMXS: begin
          // wipe and enable go low on the same edge: demultiplex with others low
          next_r.wipe_n = 1'b0;
          next_r.en_n = 1'b0;
          next_r.st = EAL_IDLE;
        end
        EAL_DMXE: begin
          // a deferred write goes back through idle, so the address moves a cycle later
          next_r.en_n = 1'b1; // enable rises a step after wipe
          next_r.st = EAL_IDLE;
        end
        default: begin
          next_r.st = EAL_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset puts the device in clear mode, disabled
  // inited stays low through reset and rises with wipe at the end of the clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '{st: EAL_CLRS, addr: 3'h0, data: 1'b0, en_n: 1'b1, wipe_n: 1'b0,
             inited: 1'b0, pend: 1'b0, paddr: 3'h0, pdata: 1'b0,
             cnt: 2'h1};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins straight from flops; addr_bit0 is the low bit
  // the three low address bits are meant to go in common to every unit
  assign addr_bit0_out = r.addr[0];
  assign addr_bit1_out = r.addr[1];
  assign addr_bit2_out = r.addr[2];
  assign data_out = r.data;
  assign enable_n_out = r.en_n;
  assign wipe_all_n_out = r.wipe_n;
  assign inited_out = r.inited;
  assign cmd_ready_out = (r.st == EAL_IDLE) && (r.cnt == 2'h0) && !r.pend;

  ////////////////////////////////////////////////////////////////////////
  // checks on the pin sequences
  // they watch the flops behind the pins, one sample per clock
  AST_ADDR_ONLY_DISABLED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $changed(r.addr) |-> r.en_n) else $error("address moved while enabled");
  AST_STROBE_AFTER_ADDR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(r.en_n) && r.wipe_n |-> $stable(r.addr) && $past(r.en_n)) else $error("strobe without stable address");
  AST_STROBE_LEN: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(r.en_n) && r.wipe_n |=> !r.en_n ##1 r.en_n) else $error("strobe length wrong");
  AST_DMX_EXIT_ORDER: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(r.wipe_n) && !$past(r.en_n) |-> !r.en_n) else $error("enable rose with wipe");
  AST_CLEAR_LEN: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(r.wipe_n) && r.en_n |=> !r.wipe_n ##1 r.wipe_n) else $error("clear pulse wrong");
  AST_CLR_ADDR_STABLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(r.wipe_n) |-> $stable(r.addr)) else $error("address moved leaving clear");
  AST_READY_IDLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    cmd_ready_out |-> r.en_n || !r.wipe_n) else $error("idle with the latch left open");
  AST_INITED_STAYS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    r.inited |=> r.inited) else $error("init flag dropped");
  AST_INITED_AFTER_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(r.inited) |-> $rose(r.wipe_n) && r.en_n) else $error("init flag rose outside a clear");
  AST_PEND_WIPE_HIGH: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    r.pend |-> r.wipe_n) else $error("deferred write with wipe low");
  AST_DMX_ENTRY_STEADY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(r.wipe_n) && !r.en_n |-> $stable(r.addr) && $stable(r.data)) else $error("demux entered on moving pins");
  AST_DATA_ONLY_DISABLED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $changed(r.data) |-> r.en_n) else $error("data moved while enabled");
  // covers for the main pin walks
  COV_WRITE: cover property (@(posedge clk_in) disable iff (!rst_b_in) $fell(r.en_n) && r.wipe_n);
  COV_DEMUX: cover property (@(posedge clk_in) disable iff (!rst_b_in) eal_is_demux(r.en_n, r.wipe_n));
  COV_WRITE_FROM_DEMUX: cover property (@(posedge clk_in) disable iff (!rst_b_in) r.pend && r.st == EAL_DMXE);
  COV_DMX_EXIT: cover property (@(posedge clk_in) disable iff (!rst_b_in) $rose(r.wipe_n) && !r.en_n);
endmodule
`default_nettype wire

// *** test/eal_latch_model.sv ***
// behavioural eight-bit addressable latch standing in for the device
`timescale 1ns/1ps
`default_nettype none
module eal_latch_model (
  input wire logic addr_bit0_in,
  input wire logic addr_bit1_in,
  input wire logic addr_bit2_in,
  input wire logic data_in,
  input wire logic enable_n_in,
  input wire logic wipe_all_n_in,
  output logic [7:0] q_out
);
  logic [2:0] sel;
  // level-sensitive latches; q_out starts unknown until cleared
  always @* begin
    sel = {addr_bit2_in, addr_bit1_in, addr_bit0_in};
    if (!wipe_all_n_in) begin
      q_out = enable_n_in ? 8'h00 : 8'(data_in) << sel;
    end else if (!enable_n_in) begin
      q_out[sel] = data_in;
    end
  end // memory mode falls through, so q_out holds
endmodule
`default_nettype wire

// *** test/eal_ctrl_tb.sv ***
// self-checking bench for the addressable latch controller
`timescale 1ns/1ps
`include "eal_defines.svh"
`default_nettype none
module eal_ctrl_tb;
  typedef struct packed {logic [1:0] op; logic [2:0] a; logic d; logic [7:0] q;} eal_row_t;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic [1:0] cmd_op_in = 2'h0;
  logic [2:0] cmd_addr_in = 3'h0;
  logic cmd_data_in = 1'b0;
  logic cmd_ready_out, addr_bit0, addr_bit1, addr_bit2, data_out, enable_n_out, wipe_all_n_out, inited_out;
  logic [7:0] q;
  int n_fail = 0;
  int tests_run = 0;
  eal_row_t rows [16] = '{
    '{`EAL_CMD_WRITE, 3'h0, 1'h1, 8'h01}, '{`EAL_CMD_WRITE, 3'h7, 1'h1, 8'h81},
    '{`EAL_CMD_WRITE, 3'h3, 1'h1, 8'h89}, '{`EAL_CMD_WRITE, 3'h0, 1'h0, 8'h88},
    '{`EAL_CMD_DEMUX, 3'h5, 1'h1, 8'h20}, '{`EAL_CMD_HOLD, 3'h5, 1'h1, 8'h20},
    '{`EAL_CMD_WRITE, 3'h2, 1'h1, 8'h24}, '{`EAL_CMD_CLEAR, 3'h0, 1'h0, 8'h00},
    '{`EAL_CMD_DEMUX, 3'h6, 1'h0, 8'h00}, '{`EAL_CMD_HOLD, 3'h0, 1'h0, 8'h00},
    '{`EAL_CMD_WRITE, 3'h6, 1'h1, 8'h40}, '{`EAL_CMD_DEMUX, 3'h7, 1'h1, 8'h80},
    '{`EAL_CMD_HOLD, 3'h7, 1'h1, 8'h80}, '{`EAL_CMD_WRITE, 3'h1, 1'h1, 8'h82},
    '{`EAL_CMD_DEMUX, 3'h3, 1'h1, 8'h08}, '{`EAL_CMD_WRITE, 3'h6, 1'h1, 8'h48}};
  eal_ctrl uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
    .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out),
    .addr_bit0_out(addr_bit0), .addr_bit1_out(addr_bit1), .addr_bit2_out(addr_bit2), .data_out(data_out),
    .enable_n_out(enable_n_out),
    .wipe_all_n_out(wipe_all_n_out), .inited_out(inited_out));
  eal_latch_model dev (.addr_bit0_in(addr_bit0), .addr_bit1_in(addr_bit1), .addr_bit2_in(addr_bit2),
    .data_in(data_out),
    .enable_n_in(enable_n_out), .wipe_all_n_in(wipe_all_n_out), .q_out(q));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait; after 40 cycles it returns and the next check sees the hang
  task automatic wait_idle();
    for (int n = 0; n < 40 && cmd_ready_out !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
    end
  endtask
  task automatic start(input logic [1:0] op, input logic [2:0] a, input logic d);
    wait_idle();
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_op_in <= op;
    cmd_addr_in <= a;
    cmd_data_in <= d;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    #1;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // address pins may only move while storage cannot happen
  always @(addr_bit0 or addr_bit1 or addr_bit2) begin
    if (enable_n_out === 1'b0 && wipe_all_n_out === 1'b1) begin
      n_fail++;
      $display("mismatch address move expected 0 seen 1");
    end
  end
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    check("reset inited", 8'h00, {7'h0, inited_out});
    rst_b_in <= 1'b1;
    wait_idle();
    check("reset q", 8'h00, q);
    check("inited", 8'h01, {7'h0, inited_out});
    foreach (rows[i]) begin
      start(rows[i].op, rows[i].a, rows[i].d);
      wait_idle();
      check("row q", rows[i].q, q);
    end
    // a request while busy is dropped, not queued
    start(`EAL_CMD_WRITE, 3'h4, 1'h1);
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_op_in <= `EAL_CMD_CLEAR;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    wait_idle();
    check("busy refuse", 8'h58, q);
    check("idle pins", 8'h03, {6'h0, enable_n_out, wipe_all_n_out});
    // reset in mid-run forces clear mode
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check("reset wipe", 8'h00, {7'h0, wipe_all_n_out});
    check("reset clears", 8'h00, q);
    check("reset inited", 8'h00, {7'h0, inited_out});
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    start(`EAL_CMD_WRITE, 3'h5, 1'h1);
    wait_idle();
    check("after reset", 8'h20, q);
    summarize();
  end
endmodule
`default_nettype wire
